//--- common/ssp_defs.svh
// Constants for the serial port transfer engine.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_MODE_SPI 3'h0
`define SSP_MODE_I2S 3'h2
`define SSP_FULL_CHAR 4'h8
`define SSP_ALL_ONES 8'hff
`define SSP_BYTE_RST 8'h00
`define SSP_HALF_ONE 16'h0001
`define SSP_SYNC_RST 5'h08
`endif

//--- common/ssp_pkg.sv
// Types shared by the serial port transfer engine.
package ssp_pkg;
  typedef struct packed {
    logic master_enable;
    logic phase;
    logic clk_polarity;
    logic [2:0] select_mode_field;
    logic select_direction;
    logic select_polarity;
    logic [2:0] character_length;
    logic [15:0] baud;
  } ssp_cfg_s;
  typedef struct packed {
    logic select_value;
    logic transmit_end_of_frame;
  } ssp_cmd_s;
  typedef struct packed {
    logic collision;
    logic tx_underrun;
    logic rx_overrun;
  } ssp_err_s;
  typedef struct packed {
    logic tx_holding_empty;
    logic rx_holding_full;
    logic transfer_status_flag;
  } ssp_stat_s;
  typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_RUN} ssp_state_e;
endpackage

//--- design/ssp_top.sv
// Serial port transfer engine with master and link-clocked slave paths.
`timescale 1ns/100ps
`include "ssp_defs.svh"
// Operation
// - Serial clock idles at the polarity level; polarity swaps edge roles.
// - Phase xor polarity zero launches falling, captures rising; else reverse.
// - Each bit is driven half a clock period before its sampling edge.
// - Serial clock toggles only while shifting, one period per bit.
// - Select mode zero drives slave select directly from select value.
// - Select value is loaded before or together with the first byte.
// - Slave select stays asserted across characters while select value set.
// - End-of-frame on last byte clears select value and itself after it.
// - A transfer status flag shows a master transaction in progress.
// - Master never overruns and underruns only in sound mode; otherwise it pauses until serviced.
// - Slave flags underrun and overrun; underrun shifts out all ones.
// - In sound mode select value marks the channel of current bytes.
// - In sound mode select changes one clock period before the data.
// - Short characters: transmit left justified, receive right justified.
// - Sound mode end stops clock, clears select; no end-of-frame underruns.
// - Master with select as input flags collision when select goes low.
// - Load sets transmit empty; finished character sets receive full.
// - Error flags clear only on writing one.
// - Select polarity chooses active level of the select pin.

module ssp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] R = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= R;
      q <= R;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // ssp_sync

module ssp_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Configuration.
  input wire ssp_pkg::ssp_cfg_s cfg,
  // Holding registers.
  input wire logic tx_wr,
  input wire logic [7:0] tx_data,
  input wire logic cmd_wr,
  input wire ssp_pkg::ssp_cmd_s cmd,
  input wire logic rx_rd,
  output logic [7:0] rx_data,
  output ssp_pkg::ssp_cmd_s cmd_state,
  // Status.
  output ssp_pkg::ssp_stat_s status,
  input wire ssp_pkg::ssp_err_s err_clear,
  output ssp_pkg::ssp_err_s err,
  // Serial pins.
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_i,
  output logic ss_o,
  output logic ss_oe
);
  import ssp_pkg::*;

  // ----------------------------------------
  // Shared decode and crossings.
  // ----------------------------------------
  logic [3:0] nbits;
  logic i2s;
  logic miso_s, ss_s, done_s, und_s, ack_s, req_s;
  logic done_tgl, und_tgl, ack_tgl, req_tgl;
  logic link_clk, link_launch;
  logic [7:0] slv_rx, slv_tx;

  assign nbits = (cfg.character_length == 3'h0) ? `SSP_FULL_CHAR :
                 {1'b0, cfg.character_length};
  assign i2s = cfg.select_mode_field == `SSP_MODE_I2S;
  assign link_clk = sck_i ^ (cfg.phase ^ cfg.clk_polarity);
  assign link_launch = ~link_clk;

  ssp_sync #(.W(5), .R(`SSP_SYNC_RST)) u_sync_clk (
    .clk(clk),
    .resetn(resetn),
    .d({miso_i, ss_i, done_tgl, und_tgl, ack_tgl}),
    .q({miso_s, ss_s, done_s, und_s, ack_s})
  );
  ssp_sync #(.W(1), .R(1'b0)) u_sync_link (
    .clk(link_launch),
    .resetn(resetn),
    .d(req_tgl),
    .q(req_s)
  );

  // ----------------------------------------
  // Master engine and holding registers.
  // ----------------------------------------
  ssp_state_e state, next_state;
  logic [15:0] half_cnt, next_half_cnt;
  logic lead, next_lead, sck, next_sck, mosi, next_mosi;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh, rx_word;
  logic [7:0] tx_hold, next_tx_hold, next_rx_data, next_slv_tx;
  logic ss_int, next_ss_int, shift_eof, next_shift_eof;
  logic tx_empty, next_tx_empty, rx_full, next_rx_full;
  logic sv, next_sv, eof, next_eof, next_req_tgl;
  logic done_q, und_q, tick, start, cap, last;
  logic next_ss_o, next_ss_oe, next_miso_oe;
  ssp_err_s next_err;

  assign tick = half_cnt <= `SSP_HALF_ONE;
  assign start = cfg.master_enable && !tx_empty && !rx_full;
  assign cap = lead != cfg.phase;
  assign last = (bit_cnt + 4'h1) == nbits;
  assign rx_word = cap ? {rx_sh[6:0], miso_s} : rx_sh;

  always_comb begin
    next_state = state;
    next_half_cnt = half_cnt;
    next_lead = lead;
    next_sck = sck;
    next_mosi = mosi;
    next_bit_cnt = bit_cnt;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_ss_int = ss_int;
    next_shift_eof = shift_eof;
    next_tx_empty = tx_empty;
    next_rx_full = rx_full;
    next_rx_data = rx_data;
    next_sv = sv;
    next_eof = eof;
    next_slv_tx = slv_tx;
    next_req_tgl = req_tgl;
    next_err = err & ~err_clear;
    if (rx_rd) begin
      next_rx_full = 1'b0;
    end
    case (state)
      SSP_IDLE: begin
        next_sck = cfg.clk_polarity;
        if (start) begin
          next_tx_empty = 1'b1;
          next_shift_eof = eof;
          next_bit_cnt = 4'h0;
          next_lead = 1'b1;
          next_half_cnt = cfg.baud;
          next_rx_sh = `SSP_BYTE_RST;
          if (cfg.phase) begin
            next_tx_sh = tx_hold;
          end else begin
            next_mosi = tx_hold[7];
            next_tx_sh = {tx_hold[6:0], 1'b0};
          end
          if (i2s && ss_int != sv) begin
            next_ss_int = sv;
            next_state = SSP_LEAD;
          end else begin
            next_state = SSP_RUN;
          end
        end
      end
      SSP_LEAD: begin
        next_half_cnt = tick ? cfg.baud : half_cnt - 16'h0001;
        if (tick) begin
          next_lead = ~lead;
          if (!lead) begin
            next_state = SSP_RUN;
          end
        end
      end
      SSP_RUN: begin
        next_half_cnt = tick ? cfg.baud : half_cnt - 16'h0001;
        if (tick) begin
          next_sck = ~sck;
          next_lead = ~lead;
          if (cap) begin
            next_rx_sh = {rx_sh[6:0], miso_s};
          end
          if ((cfg.phase && lead) || (!cfg.phase && !lead && !last)) begin
            next_mosi = tx_sh[7];
            next_tx_sh = {tx_sh[6:0], 1'b0};
          end
          if (!lead) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (last) begin
              next_state = SSP_IDLE;
              next_rx_data = rx_word;
              next_rx_full = 1'b1;
              if (shift_eof) begin
                next_sv = 1'b0;
                next_eof = 1'b0;
              end else if (i2s && tx_empty && !tx_wr) begin
                next_err.tx_underrun = 1'b1;
                next_sv = 1'b0;
                next_eof = 1'b0;
              end
              if (i2s && (shift_eof || (tx_empty && !tx_wr))) begin
                next_ss_int = 1'b0;
              end
            end
          end
        end
      end
      default: begin
        next_state = SSP_IDLE;
      end
    endcase
    if (!cfg.master_enable && !tx_empty && req_tgl == ack_s) begin
      next_slv_tx = tx_hold;
      next_req_tgl = ~req_tgl;
      next_tx_empty = 1'b1;
    end
    if (done_s != done_q) begin
      if (rx_full && !rx_rd) begin
        next_err.rx_overrun = 1'b1;
      end else begin
        next_rx_data = slv_rx;
        next_rx_full = 1'b1;
      end
    end
    if (und_s != und_q) begin
      next_err.tx_underrun = 1'b1;
    end
    if (cfg.master_enable && !cfg.select_direction && !ss_s) begin
      next_err.collision = 1'b1;
    end
    if (tx_wr) begin
      next_tx_hold = tx_data;
      next_tx_empty = 1'b0;
    end else begin
      next_tx_hold = tx_hold;
    end
    if (cmd_wr) begin
      next_sv = cmd.select_value;
      next_eof = cmd.transmit_end_of_frame;
    end
    if (!i2s) begin
      next_ss_int = sv;
    end
    next_ss_o = cfg.select_polarity ? next_ss_int : ~next_ss_int;
    next_ss_oe = cfg.master_enable && cfg.select_direction;
    next_miso_oe = !cfg.master_enable && (ss_s == cfg.select_polarity);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SSP_IDLE;
      half_cnt <= `SSP_HALF_ONE;
      lead <= 1'b1;
      sck <= 1'b0;
      mosi <= 1'b0;
      bit_cnt <= 4'h0;
      tx_sh <= `SSP_BYTE_RST;
      rx_sh <= `SSP_BYTE_RST;
      ss_int <= 1'b0;
      shift_eof <= 1'b0;
      tx_empty <= 1'b1;
      rx_full <= 1'b0;
      rx_data <= `SSP_BYTE_RST;
      tx_hold <= `SSP_BYTE_RST;
      sv <= 1'b0;
      eof <= 1'b0;
      err <= '0;
      slv_tx <= `SSP_BYTE_RST;
      req_tgl <= 1'b0;
      done_q <= 1'b0;
      und_q <= 1'b0;
      ss_o <= 1'b1;
      ss_oe <= 1'b0;
      miso_oe <= 1'b0;
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
      status <= '0;
    end else begin
      state <= next_state;
      half_cnt <= next_half_cnt;
      lead <= next_lead;
      sck <= next_sck;
      mosi <= next_mosi;
      bit_cnt <= next_bit_cnt;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      ss_int <= next_ss_int;
      shift_eof <= next_shift_eof;
      tx_empty <= next_tx_empty;
      rx_full <= next_rx_full;
      rx_data <= next_rx_data;
      tx_hold <= next_tx_hold;
      sv <= next_sv;
      eof <= next_eof;
      err <= next_err;
      slv_tx <= next_slv_tx;
      req_tgl <= next_req_tgl;
      done_q <= done_s;
      und_q <= und_s;
      ss_o <= next_ss_o;
      ss_oe <= next_ss_oe;
      miso_oe <= next_miso_oe;
      sck_oe <= cfg.master_enable;
      mosi_oe <= cfg.master_enable;
      status <= {next_tx_empty, next_rx_full,
                 next_state != SSP_IDLE};
    end
  end

  assign sck_o = sck;
  assign mosi_o = mosi;
  assign cmd_state = {sv, eof};

  // ----------------------------------------
  // Slave path on the link clock.
  // ----------------------------------------
  logic [7:0] s_rx_sh, next_s_rx_sh, next_slv_rx, s_tx, next_s_tx;
  logic [3:0] s_cnt, next_s_cnt;
  logic next_done_tgl, next_ack_tgl, next_und_tgl, next_miso;

  always_comb begin
    next_s_rx_sh = {s_rx_sh[6:0], mosi_i};
    next_s_cnt = s_cnt + 4'h1;
    next_slv_rx = slv_rx;
    next_done_tgl = done_tgl;
    if ((s_cnt + 4'h1) == nbits) begin
      next_slv_rx = next_s_rx_sh;
      next_s_rx_sh = `SSP_BYTE_RST;
      next_s_cnt = 4'h0;
      next_done_tgl = ~done_tgl;
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      s_rx_sh <= `SSP_BYTE_RST;
      s_cnt <= 4'h0;
      slv_rx <= `SSP_BYTE_RST;
      done_tgl <= 1'b0;
    end else begin
      s_rx_sh <= next_s_rx_sh;
      s_cnt <= next_s_cnt;
      slv_rx <= next_slv_rx;
      done_tgl <= next_done_tgl;
    end
  end

  always_comb begin
    next_ack_tgl = ack_tgl;
    next_und_tgl = und_tgl;
    next_miso = s_tx[7];
    next_s_tx = {s_tx[6:0], 1'b1};
    if (s_cnt == 4'h0) begin
      if (req_s != ack_tgl) begin
        next_ack_tgl = ~ack_tgl;
        next_miso = slv_tx[7];
        next_s_tx = {slv_tx[6:0], 1'b1};
      end else begin
        next_und_tgl = und_tgl ^ !cfg.master_enable;
        next_miso = 1'b1;
        next_s_tx = `SSP_ALL_ONES;
      end
    end
  end

  always_ff @(posedge link_launch or negedge resetn) begin
    if (!resetn) begin
      ack_tgl <= 1'b0;
      und_tgl <= 1'b0;
      miso_o <= 1'b1;
      s_tx <= `SSP_ALL_ONES;
    end else begin
      ack_tgl <= next_ack_tgl;
      und_tgl <= next_und_tgl;
      miso_o <= next_miso;
      s_tx <= next_s_tx;
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  sequence char_end_seq;
    state == SSP_RUN && tick && !lead && last;
  endsequence

  chk_idle_sck_level: assert property (@(posedge clk) disable iff (!resetn)
    state == SSP_IDLE |=> sck_o == $past(cfg.clk_polarity))
    else $error("serial clock not at idle level");
  chk_sck_half_toggle: assert property (@(posedge clk) disable iff (!resetn)
    (state == SSP_RUN && tick) |=> sck_o != $past(sck_o))
    else $error("serial clock did not toggle on half period");
  chk_select_follows: assert property (@(posedge clk) disable iff (!resetn)
    !i2s |=> ss_o == ($past(cfg.select_polarity) ?
      $past(sv) : !$past(sv)))
    else $error("select pin does not follow select value");
  chk_eof_clears_sv: assert property (@(posedge clk) disable iff (!resetn)
    (char_end_seq ##0 (shift_eof && !cmd_wr)) |=> !sv && !eof)
    else $error("end of frame did not clear select value");
  chk_master_no_under: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.master_enable && !i2s && und_s == und_q && !err.tx_underrun)
      |=> !err.tx_underrun)
    else $error("master raised underrun in select mode zero");
  chk_pause_rx_full: assert property (@(posedge clk) disable iff (!resetn)
    (state == SSP_IDLE && rx_full) |=> state == SSP_IDLE)
    else $error("master started while receive register full");
  chk_collision_set: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.master_enable && !cfg.select_direction && !ss_s)
      |=> err.collision)
    else $error("collision not flagged");
  chk_w1c_hold: assert property (@(posedge clk) disable iff (!resetn)
    (err.collision && !err_clear.collision) |=> err.collision)
    else $error("collision flag cleared without write of one");
  chk_tx_load_empty: assert property (@(posedge clk) disable iff (!resetn)
    (state == SSP_IDLE && start && !tx_wr)
      |=> tx_empty && state != SSP_IDLE ##0 status.tx_holding_empty)
    else $error("transmit empty not set on load");
  chk_slave_ones: assert property (@(posedge link_launch)
    disable iff (!resetn)
    (s_cnt == 4'h0 && req_s == ack_tgl) |=> miso_o && s_tx == 8'hff)
    else $error("slave underrun did not send ones");
endmodule // ssp_top

//--- verification/ssp_slave_model.sv
// Behavioural SPI slave facing the serial port in master mode.
`timescale 1ns/100ps
module ssp_slave_model (
  // Serial pins.
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  // Format and data.
  input wire logic phase,
  input wire logic clk_polarity,
  input wire logic [7:0] reply,
  output logic [7:0] got
);
  // ----
  // Shifting.
  // ----
  logic [7:0] sh;
  int n;
  initial begin
    miso = 1'b1;
    got = 8'h00;
    sh = 8'h00;
    n = 0;
  end
  // A released line shows the inverse of its last value.
  always @(posedge ss_n) miso = ~miso;
  always @(negedge ss_n) begin
    sh = reply;
    n = 0;
    if (!phase) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
  // The capture edge is rising when phase equals polarity.
  always @(sck) begin
    if (!ss_n && (sck ^ clk_polarity ^ phase)) begin
      got = {got[6:0], mosi};
      n++;
      if (n == 8) begin
        n = 0;
        sh = reply;
      end
    end else if (!ss_n) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
endmodule // ssp_slave_model

//--- verification/serial_port_spi_i2s_transfer_bench.sv
// Self-checking bench for the serial port transfer engine.
`timescale 1ns/100ps
`include "ssp_defs.svh"
`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); \
  end \
end
module serial_port_spi_i2s_transfer_bench;
  import ssp_pkg::*;
  // ----
  // Signals.
  // ----
  logic clk, resetn, tx_wr, cmd_wr, rx_rd, sck_i, mosi_i, ss_i;
  ssp_cfg_s cfg;
  ssp_cmd_s cmd, cmd_state;
  ssp_err_s err_clear, err;
  ssp_stat_s status;
  logic [7:0] tx_data, rx_data, reply, got, s;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_m, miso_o, miso_oe;
  logic ss_o, ss_oe, sck_d;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int tog = 0;
  int t0;
  ssp_top ssp_top_i (
    .clk(clk),
    .resetn(resetn),
    .cfg(cfg),
    .tx_wr(tx_wr),
    .tx_data(tx_data),
    .cmd_wr(cmd_wr),
    .cmd(cmd),
    .rx_rd(rx_rd),
    .rx_data(rx_data),
    .cmd_state(cmd_state),
    .status(status),
    .err_clear(err_clear),
    .err(err),
    .sck_i(sck_i),
    .sck_o(sck_o),
    .sck_oe(sck_oe),
    .mosi_i(mosi_i),
    .mosi_o(mosi_o),
    .mosi_oe(mosi_oe),
    .miso_i(miso_m),
    .miso_o(miso_o),
    .miso_oe(miso_oe),
    .ss_i(ss_i),
    .ss_o(ss_o),
    .ss_oe(ss_oe)
  );
  ssp_slave_model ssp_slave_model_i (
    .sck(sck_o),
    .ss_n(ss_o ^ cfg.select_polarity),
    .mosi(mosi_o),
    .miso(miso_m),
    .phase(cfg.phase),
    .clk_polarity(cfg.clk_polarity),
    .reply(reply),
    .got(got)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Counts serial clock toggles and cuts a hang short.
  always @(posedge clk) begin
    sck_d <= sck_o;
    tog <= tog + int'(sck_o !== sck_d);
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failures++;
      final_report;
    end
  end
  // ----
  // Access tasks.
  // ----
  task automatic final_report;
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic setc(input logic me, ph, po, input logic [2:0] md,
                      input logic sd, sp, input logic [2:0] cl);
    @(posedge clk);
    cfg <= '{me, ph, po, md, sd, sp, cl, 16'h0003};
    repeat (4) @(posedge clk);
  endtask
  task automatic put(input ssp_cmd_s c, input logic t, input logic [7:0] b);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd <= c;
    tx_wr <= t;
    tx_data <= b;
    @(posedge clk);
    cmd_wr <= 1'b0;
    tx_wr <= 1'b0;
  endtask
  task automatic pulse(input logic r, input ssp_err_s e);
    @(posedge clk);
    rx_rd <= r;
    err_clear <= e;
    @(posedge clk);
    rx_rd <= 1'b0;
    err_clear <= 3'h0;
    @(posedge clk);
  endtask
  task automatic wait_rx;
    for (int i = 0; i < 300 && status.rx_holding_full !== 1'b1; i++)
      @(posedge clk);
    `CHK(status.rx_holding_full, 1'b1)
  endtask
  task automatic frame(input logic [7:0] m);
    ss_i <= 1'b0;
    #53;
    for (int i = 7; i >= 0; i--) begin
      mosi_i <= m[i];
      #24;
      sck_i <= 1'b1;
      s[i] = miso_o;
      #24;
      sck_i <= 1'b0;
    end
    #50;
    ss_i <= 1'b1;
    mosi_i <= ~m[0];
    repeat (10) @(posedge clk);
  endtask
  // ----
  // Tests.
  // ----
  initial begin
    resetn = 1'b0;
    cfg = '0;
    tx_wr = 1'b0;
    tx_data = 8'h00;
    cmd_wr = 1'b0;
    cmd = '0;
    rx_rd = 1'b0;
    err_clear = '0;
    sck_i = 1'b0;
    mosi_i = 1'b0;
    ss_i = 1'b1;
    reply = 8'h00;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(status, 3'b100)
    `CHK(err, 3'h0)
    `CHK(sck_oe, 1'b0)
    for (int k = 0; k < 4; k++) begin
      setc(1'b1, k[1], k[0], `SSP_MODE_SPI, 1'b1, k[0], 3'h0);
      `CHK(sck_o, k[0])
      `CHK(ss_o, ~k[0])
      reply <= 8'h5a ^ 8'(k);
      t0 = tog;
      put(2'b10, 1'b1, 8'hc3);
      repeat (8) @(posedge clk);
      `CHK(status.transfer_status_flag, 1'b1)
      `CHK(ss_o, k[0])
      wait_rx;
      `CHK(rx_data, reply)
      `CHK(got, 8'hc3)
      put(2'b11, 1'b1, 8'h3c);
      repeat (30) @(posedge clk);
      `CHK(tog - t0, 16)
      `CHK(ss_o, k[0])
      pulse(1'b1, 3'h0);
      `CHK(status.rx_holding_full, 1'b0)
      wait_rx;
      `CHK(rx_data, reply)
      `CHK(got, 8'h3c)
      repeat (10) @(posedge clk);
      `CHK(tog - t0, 32)
      `CHK(ss_o, ~k[0])
      `CHK(cmd_state, 2'b00)
      `CHK(err, 3'h0)
      pulse(1'b1, 3'h0);
    end
    setc(1'b1, 1'b0, 1'b0, `SSP_MODE_SPI, 1'b1, 1'b0, 3'h4);
    reply <= 8'hd0;
    t0 = tog;
    put(2'b10, 1'b1, 8'hb0);
    wait_rx;
    `CHK(rx_data[3:0], 4'hd)
    `CHK(got[3:0], 4'hb)
    put(2'b00, 1'b0, 8'h00);
    repeat (4) @(posedge clk);
    `CHK(ss_o, 1'b1)
    `CHK(tog - t0, 8)
    pulse(1'b1, 3'h0);
    setc(1'b1, 1'b0, 1'b0, `SSP_MODE_I2S, 1'b1, 1'b0, 3'h0);
    t0 = tog;
    put(2'b10, 1'b1, 8'h96);
    wait_rx;
    repeat (4) @(posedge clk);
    `CHK(err.tx_underrun, 1'b1)
    `CHK(cmd_state, 2'b00)
    `CHK(ss_o, 1'b1)
    `CHK(tog - t0, 16)
    pulse(1'b1, 3'b010);
    `CHK(err, 3'h0)
    setc(1'b1, 1'b0, 1'b0, `SSP_MODE_SPI, 1'b1, 1'b0, 3'h0);
    ss_i <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(err.collision, 1'b0)
    setc(1'b1, 1'b0, 1'b0, `SSP_MODE_SPI, 1'b0, 1'b0, 3'h0);
    `CHK(err.collision, 1'b1)
    `CHK(ss_oe, 1'b0)
    ss_i <= 1'b1;
    pulse(1'b0, 3'b011);
    `CHK(err.collision, 1'b1)
    pulse(1'b0, 3'b100);
    `CHK(err.collision, 1'b0)
    // Format changes above clocked the slave counter, so reset it again.
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(status, 3'b100)
    `CHK(err, 3'h0)
    setc(1'b0, 1'b0, 1'b0, `SSP_MODE_SPI, 1'b0, 1'b0, 3'h0);
    frame(8'h3c);
    `CHK(s, 8'hff)
    `CHK(rx_data, 8'h3c)
    `CHK(err, 3'b010)
    put(2'b00, 1'b1, 8'ha5);
    frame(8'h81);
    `CHK(err, 3'b011)
    `CHK(rx_data, 8'h3c)
    pulse(1'b1, 3'b011);
    `CHK(err, 3'h0)
    frame(8'h42);
    `CHK(s, 8'ha5)
    `CHK(rx_data, 8'h42)
    `CHK(err.rx_overrun, 1'b0)
    final_report;
  end
endmodule // serial_port_spi_i2s_transfer_bench
